/* pkg/timer_irq_pkg.sv */
/*
  Package for the timer interrupt bookkeeping block: register offsets,
  source bit positions, reset values and the bus access struct.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
`default_nettype none
package timer_irq_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_ENABLE_MASK = 8'h18;
  localparam logic [7:0] OFF_RAW_STATUS  = 8'h1c;
  localparam logic [7:0] OFF_MASKED      = 8'h20;
  localparam logic [7:0] OFF_CLEAR       = 8'h24;

  // ---------------------------------------------------------------
  // Source bit positions
  // ---------------------------------------------------------------
  localparam int BIT_A_TIMEOUT  = 0;
  localparam int BIT_A_CAP_MTCH = 1;
  localparam int BIT_A_CAP_EVT  = 2;
  localparam int BIT_RTC_EVT    = 3;
  localparam int BIT_B_TIMEOUT  = 8;
  localparam int BIT_B_CAP_MTCH = 9;
  localparam int BIT_B_CAP_EVT  = 10;

  // Implemented bits of every interrupt register
  localparam logic [31:0] SRC_BITS  = 32'h0000070f;
  localparam logic [31:0] MASK_RST  = 32'h00000000;
  localparam logic [31:0] RAW_RST   = 32'h00000000;
  localparam logic [31:0] RDATA_RST = 32'h00000000;

  // Bus request as seen by the slave
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } bus_req_s;

endpackage
`default_nettype wire

/* logic/timer_irq.sv */
/*
  Interrupt enable mask, raw and masked status, and write-one-to-clear
  for the seven timer sources, behind an Avalon-MM slave.
  Assumes source event pulses come from logic on clock_i.
*/
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module timer_irq (
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [3:0]  avs_byteenable_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        half_a_timeout_i,
  input  wire logic        half_a_capture_match_i,
  input  wire logic        half_a_capture_event_i,
  input  wire logic        rtc_event_i,
  input  wire logic        half_b_timeout_i,
  input  wire logic        half_b_capture_match_i,
  input  wire logic        half_b_capture_event_i,
  output logic             irq_o
);

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  timer_irq_pkg::bus_req_s req;
  logic        ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] mask_r, mask_nxt;
  logic [31:0] raw_r, raw_nxt;
  logic [31:0] events;
  logic [31:0] be_bits;
  logic        wr_take;
  logic        rd_take;
  logic        mask_hit;
  logic        clr_hit;

  function automatic logic [31:0] lanes(input logic [3:0] be);
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  assign req = '{read: avs_read_i, write: avs_write_i, address: avs_address_i,
                 byteenable: avs_byteenable_i, writedata: avs_writedata_i};

  // One wait cycle: request taken on the edge where ack_r is high
  assign avs_waitrequest_o = (req.read | req.write) & ~ack_r;
  assign wr_take = req.write & ack_r;
  assign rd_take = req.read & ack_r;
  assign be_bits = lanes(req.byteenable) & req.writedata;
  assign mask_hit = wr_take & (req.address == timer_irq_pkg::OFF_ENABLE_MASK);
  assign clr_hit  = wr_take & (req.address == timer_irq_pkg::OFF_CLEAR);

  always_comb begin
    events = 32'h00000000;
    events[timer_irq_pkg::BIT_A_TIMEOUT]  = half_a_timeout_i;
    events[timer_irq_pkg::BIT_A_CAP_MTCH] = half_a_capture_match_i;
    events[timer_irq_pkg::BIT_A_CAP_EVT]  = half_a_capture_event_i;
    events[timer_irq_pkg::BIT_RTC_EVT]    = rtc_event_i;
    events[timer_irq_pkg::BIT_B_TIMEOUT]  = half_b_timeout_i;
    events[timer_irq_pkg::BIT_B_CAP_MTCH] = half_b_capture_match_i;
    events[timer_irq_pkg::BIT_B_CAP_EVT]  = half_b_capture_event_i;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    ack_nxt   = (req.read | req.write) & ~ack_r;
    mask_nxt  = mask_r;
    raw_nxt   = raw_r;
    rdata_nxt = rdata_r;
    if (wr_take && req.address == timer_irq_pkg::OFF_ENABLE_MASK) begin
      // Byte lanes merge; unused bits never stored
      mask_nxt = ((mask_r & ~lanes(req.byteenable)) | be_bits)
                 & timer_irq_pkg::SRC_BITS;
    end
    if (wr_take && req.address == timer_irq_pkg::OFF_CLEAR) begin
      raw_nxt = raw_r & ~be_bits;
    end
    // Set wins over a clear in the same cycle, mask ignored
    raw_nxt = (raw_nxt | events) & timer_irq_pkg::SRC_BITS;
    // Snapshot in the wait cycle so the word comes from a flop
    if (req.read && !ack_r) begin
      case (req.address)
        timer_irq_pkg::OFF_ENABLE_MASK: rdata_nxt = mask_r;
        timer_irq_pkg::OFF_RAW_STATUS:  rdata_nxt = raw_r;
        timer_irq_pkg::OFF_MASKED:      rdata_nxt = raw_r & mask_r;
        default:                        rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      ack_r   <= 1'b0;
      mask_r  <= timer_irq_pkg::MASK_RST;
      raw_r   <= timer_irq_pkg::RAW_RST;
      rdata_r <= timer_irq_pkg::RDATA_RST;
    end else begin
      ack_r   <= ack_nxt;
      mask_r  <= mask_nxt;
      raw_r   <= raw_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Word sampled one cycle before the take; it stands unchanged while
  // waitrequest is low, at the cost of missing an event in that cycle.
  assign avs_readdata_o = rdata_r;

  assign irq_o = |(raw_r & mask_r);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_mask_reset;
    @(posedge clock_i) !rstn_i |=> (mask_r == timer_irq_pkg::MASK_RST);
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("mask not zero after reset");

  property p_mask_write;
    @(posedge clock_i) disable iff (!rstn_i)
      (mask_hit && req.byteenable == 4'hf)
      |=> (mask_r == ($past(req.writedata) & timer_irq_pkg::SRC_BITS));
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost");

  property p_mask_low_bits;
    @(posedge clock_i) disable iff (!rstn_i)
      (mask_hit && req.byteenable[0])
      |=> (mask_r[3:0] == $past(req.writedata[3:0]));
  endproperty
  a_mask_low_bits: assert property (p_mask_low_bits) else $error("mask low bits wrong");

  property p_mask_hold;
    @(posedge clock_i) disable iff (!rstn_i)
      !mask_hit |=> $stable(mask_r);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("mask changed without write");

  property p_unused_zero;
    @(posedge clock_i) disable iff (!rstn_i)
      (mask_r[31:11] == 21'h0) && (mask_r[7:4] == 4'h0) && (raw_r[7:4] == 4'h0);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits set");

  property p_clear_reads_zero;
    @(posedge clock_i) disable iff (!rstn_i)
      (rd_take && req.address == timer_irq_pkg::OFF_CLEAR)
      |-> (avs_readdata_o == 32'h00000000);
  endproperty
  a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("clear read not zero");

  property p_event_sets;
    @(posedge clock_i) disable iff (!rstn_i)
      (|events) |=> ((raw_r & $past(events)) == $past(events));
  endproperty
  a_event_sets: assert property (p_event_sets) else $error("event did not set raw");

  property p_raw_reset;
    @(posedge clock_i) !rstn_i |=> (raw_r == timer_irq_pkg::RAW_RST);
  endproperty
  a_raw_reset: assert property (p_raw_reset) else $error("raw not zero after reset");

  property p_raw_read;
    @(posedge clock_i) disable iff (!rstn_i)
      (rd_take && req.address == timer_irq_pkg::OFF_RAW_STATUS)
      |-> (avs_readdata_o == $past(raw_r));
  endproperty
  a_raw_read: assert property (p_raw_read) else $error("raw read wrong");

  property p_raw_holds;
    @(posedge clock_i) disable iff (!rstn_i)
      (raw_r[0] && !(clr_hit && be_bits[0])) |=> raw_r[0];
  endproperty
  a_raw_holds: assert property (p_raw_holds) else $error("raw bit dropped");

  property p_masked_and;
    @(posedge clock_i) disable iff (!rstn_i)
      (rd_take && req.address == timer_irq_pkg::OFF_MASKED)
      |-> (avs_readdata_o == $past(raw_r & mask_r));
  endproperty
  a_masked_and: assert property (p_masked_and) else $error("masked read wrong");

  property p_clear;
    @(posedge clock_i) disable iff (!rstn_i)
      (clr_hit && be_bits[10] && !half_b_capture_event_i)
      |=> !raw_r[10];
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");

  property p_irq;
    @(posedge clock_i) disable iff (!rstn_i)
      irq_o == ((raw_r & mask_r) != 32'h0);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_irq_reset;
    @(posedge clock_i) !rstn_i |=> !irq_o;
  endproperty
  a_irq_reset: assert property (p_irq_reset) else $error("irq high after reset");

  property p_one_wait;
    @(posedge clock_i) disable iff (!rstn_i)
      ((req.read | req.write) && !ack_r) |=> ack_r;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("more than one wait cycle");

  property p_ack_pulse;
    @(posedge clock_i) disable iff (!rstn_i)
      ack_r |=> !ack_r;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("request taken twice");

  // ---------------------------------------------------------------
  // Per-source checks
  // ---------------------------------------------------------------
  // Every implemented bit gets the same set; unused bits must stay zero
  genvar g;
  for (g = 0; g < 32; g++) begin : g_bit
    if (timer_irq_pkg::SRC_BITS[g]) begin : g_src
      property p_bit_set;
        @(posedge clock_i) disable iff (!rstn_i)
          events[g] |=> raw_r[g];
      endproperty
      a_bit_set: assert property (p_bit_set) else $error("source event lost");

      property p_bit_hold;
        @(posedge clock_i) disable iff (!rstn_i)
          (raw_r[g] && !(clr_hit && be_bits[g])) |=> raw_r[g];
      endproperty
      a_bit_hold: assert property (p_bit_hold) else $error("raw bit dropped");

      property p_bit_clear;
        @(posedge clock_i) disable iff (!rstn_i)
          (clr_hit && be_bits[g] && !events[g]) |=> !raw_r[g];
      endproperty
      a_bit_clear: assert property (p_bit_clear) else $error("raw bit not cleared");

      property p_bit_rise;
        @(posedge clock_i) disable iff (!rstn_i)
          (!raw_r[g] && !events[g]) |=> !raw_r[g];
      endproperty
      a_bit_rise: assert property (p_bit_rise) else $error("raw bit set with no event");

      property p_bit_masked;
        @(posedge clock_i) disable iff (!rstn_i)
          (raw_r[g] && mask_r[g]) |-> irq_o;
      endproperty
      a_bit_masked: assert property (p_bit_masked) else $error("masked source not raised");
    end else begin : g_unused
      property p_bit_unused;
        @(posedge clock_i) disable iff (!rstn_i)
          !mask_r[g] && !raw_r[g];
      endproperty
      a_bit_unused: assert property (p_bit_unused) else $error("unused bit stored");
    end
  end

  // ---------------------------------------------------------------
  // Covers
  // ---------------------------------------------------------------
  c_event_irq: cover property (@(posedge clock_i) disable iff (!rstn_i) $rose(irq_o));
  c_clear:     cover property (@(posedge clock_i) disable iff (!rstn_i)
                 clr_hit);
  c_race:      cover property (@(posedge clock_i) disable iff (!rstn_i)
                 clr_hit && |(be_bits & events));
  c_lanes:     cover property (@(posedge clock_i) disable iff (!rstn_i)
                 mask_hit && req.byteenable != 4'hf);

endmodule // timer_irq
`default_nettype wire

/* test/tb.sv */
/*
  Self-checking bench for timer_irq: an integer model of the mask and the
  raw status is compared with every read and with irq_o.
  Allows the slave up to 19 wait cycles per request; the design states one.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, w) begin n_tests++; if ((g) !== (w)) begin bad_count++; \
  $display("unexpected at %0t got %h want %h", $time, g, w); end end
module tb;
  logic        clock_i = 1'b0;
  logic        rstn_i  = 1'b0;
  logic        rd      = 1'b0;
  logic        wr      = 1'b0;
  logic [7:0]  addr    = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic [6:0]  ev      = 7'h00;
  logic [3:0]  be      = 4'hf;
  logic [31:0] ln;
  logic [31:0] rdata, q, mask_m, raw_m, seed;
  logic        irq, wreq;
  int          bad_count = 0;
  int          n_tests   = 0;

  timer_irq dut (
    .clock_i(clock_i), .rstn_i(rstn_i), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_byteenable_i(be), .avs_writedata_i(wdata),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .half_a_timeout_i(ev[0]), .half_a_capture_match_i(ev[1]),
    .half_a_capture_event_i(ev[2]), .rtc_event_i(ev[3]), .half_b_timeout_i(ev[4]),
    .half_b_capture_match_i(ev[5]), .half_b_capture_event_i(ev[6]), .irq_o(irq));

  initial begin
    forever #5 clock_i = ~clock_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = (s >> 1) ^ (s[0] ? 32'h80200003 : 32'h0);
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Bus cycle: hold the request until waitrequest is seen low
  // ---------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dv);
    int i;
    i = 0;
    addr <= a;
    wdata <= dv;
    wr <= w;
    rd <= !w;
    do begin
      @(negedge clock_i);
      i++;
    end while (wreq !== 1'b0 && i < 20);
    if (wreq !== 1'b0) begin
      bad_count++;
      test_done();
    end
    q = rdata;
    @(posedge clock_i);
    ln = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    if (w && a == timer_irq_pkg::OFF_ENABLE_MASK) begin
      mask_m = ((mask_m & ~ln) | (dv & ln)) & timer_irq_pkg::SRC_BITS;
    end
    if (w && a == timer_irq_pkg::OFF_CLEAR) raw_m = raw_m & ~(dv & ln);
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clock_i);
  endtask

  // Raw layout: half A and the RTC in 3:0, half B in 10:8
  task automatic pulse(input logic [6:0] e);
    ev <= e;
    @(posedge clock_i);
    ev <= 7'h00;
    raw_m = raw_m | {21'h0, e[6:4], 4'h0, e[3:0]};
    @(posedge clock_i);
  endtask

  initial begin
    seed = 32'd91;
    mask_m = 32'h0;
    raw_m = 32'h0;
    repeat (5) @(posedge clock_i);
    rstn_i <= 1'b1;
    @(posedge clock_i);
    for (int k = 0; k < 3; k++) begin
      bus(1'b0, 8'(8'h18 + 4 * k), 32'h0);
      `CHK(q, 32'h0)
    end
    `CHK(irq, 1'b0)
    $display("test reset done");
    // First seven rounds walk one source each, the rest are random
    for (int k = 0; k < 24; k++) begin
      seed = lfsr(seed);
      pulse(k < 7 ? 7'(1 << k) : seed[6:0]);
      seed = lfsr(seed);
      be <= seed[19:16];
      bus(1'b1, timer_irq_pkg::OFF_ENABLE_MASK, seed & timer_irq_pkg::SRC_BITS);
      bus(0, timer_irq_pkg::OFF_ENABLE_MASK, 0);
      `CHK(q, mask_m)
      bus(1'b1, timer_irq_pkg::OFF_RAW_STATUS, ~raw_m & timer_irq_pkg::SRC_BITS);
      bus(1'b1, timer_irq_pkg::OFF_MASKED, seed & timer_irq_pkg::SRC_BITS);
      bus(0, timer_irq_pkg::OFF_RAW_STATUS, 0);
      `CHK(q, raw_m)
      bus(0, timer_irq_pkg::OFF_MASKED, 0);
      `CHK(q, raw_m & mask_m)
      @(negedge clock_i);
      `CHK(irq, |(raw_m & mask_m))
      @(posedge clock_i);
      seed = lfsr(seed);
      be <= seed[23:20];
      bus(1'b1, timer_irq_pkg::OFF_CLEAR, seed & timer_irq_pkg::SRC_BITS);
      bus(0, timer_irq_pkg::OFF_RAW_STATUS, 0);
      `CHK(q, raw_m)
      bus(0, timer_irq_pkg::OFF_MASKED, 0);
      `CHK(q, raw_m & mask_m)
    end
    $display("test events done");
    // Events held through a full clear: the set must win
    be <= 4'hf;
    ev <= 7'h7f;
    bus(1'b1, timer_irq_pkg::OFF_CLEAR, timer_irq_pkg::SRC_BITS);
    ev <= 7'h00;
    raw_m = timer_irq_pkg::SRC_BITS;
    bus(0, timer_irq_pkg::OFF_RAW_STATUS, 0);
    `CHK(q, raw_m)
    $display("test race done");
    rstn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rstn_i <= 1'b1;
    mask_m = 32'h0;
    raw_m = 32'h0;
    @(posedge clock_i);
    bus(0, timer_irq_pkg::OFF_ENABLE_MASK, 0);
    `CHK(q, mask_m)
    bus(0, timer_irq_pkg::OFF_RAW_STATUS, 0);
    `CHK(q, raw_m)
    `CHK(irq, 1'b0)
    $display("test reset again done");
    bus(1'b1, 8'h40, seed);
    bus(0, 8'h40, 0);
    `CHK(q, 32'h0)
    bus(0, timer_irq_pkg::OFF_CLEAR, 0);
    `CHK(q, 32'h0)
    $display("test unmapped done");
    test_done();
  end
endmodule // tb
`default_nettype wire
